// >>> rtl/ifc_pkg.sv
// ============================================================
// shared constants of the interrupt flag controller
// ============================================================
package ifc_pkg;

    // ========================================================
    // source counts
    // ========================================================
    localparam int NUM_VEC_LINES = 4; // individually vectored pins
    localparam int NUM_SHARED = 8; // pins sharing one vector
    localparam int NUM_PERIPH = 21; // internal peripheral sources
    localparam int NUM_EXTRA = 16; // peripheral flags in extra registers
    localparam int NUM_VECTORS = 24; // vector numbers 0 to 23
    localparam int VEC_W = 5; // width of a vector number
    localparam int SYNC_STAGES = 3; // flops on every pin input

    // ========================================================
    // register byte offsets (low address bits only)
    // ========================================================
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_FIRST_REQ = 8'h00;
    localparam logic [7:0] OFS_SECOND_REQ = 8'h04;
    localparam logic [7:0] OFS_SHARED_REQ = 8'h08;
    localparam logic [7:0] OFS_FIRST_EN = 8'h0C;
    localparam logic [7:0] OFS_SECOND_EN = 8'h10;
    localparam logic [7:0] OFS_THIRD_EN = 8'h14;
    localparam logic [7:0] OFS_FIRST_EDGE = 8'h18;
    localparam logic [7:0] OFS_SECOND_EDGE = 8'h1C;
    localparam logic [7:0] OFS_EXTRA_REQ = 8'h20;
    localparam logic [7:0] OFS_EXTRA_EN = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // ========================================================
    // field positions and reset values
    // ========================================================
    localparam int BIT_TIMER_B1 = 7; // first request/enable register
    localparam int BIT_TIMER_A = 6;
    localparam int BIT_FIXED_ONE = 4; // reserved, reads as one
    localparam int BIT_DIRECT = 7; // second request/enable register
    localparam int BIT_ADC = 6;
    localparam int BIT_SERIAL1 = 4;
    localparam int BIT_STAT_REQ = 8; // status: request line
    localparam logic [7:0] RST_FIRST_REQ = 8'h10;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [15:0] RST_REG16 = 16'h0000;

    // peripheral source index inside the internal flag vector
    localparam int PIDX_TIMER_A = 0;
    localparam int PIDX_TIMER_B1 = 1;
    localparam int PIDX_DIRECT = 2;
    localparam int PIDX_ADC = 3;
    localparam int PIDX_SERIAL1 = 4;
    localparam int PIDX_EXTRA = 5;

    // ========================================================
    // vector numbers
    // ========================================================
    localparam int VEC_FIRST_LINE = 4; // line 0 on 4, line 3 on 7
    localparam int VEC_SHARED = 8;
    localparam int VEC_PERIPH_FIRST = 9;
    localparam int VEC_PERIPH_LAST = 23;

    // ========================================================
    // AHB-Lite encodings
    // ========================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// >>> rtl/ifc_pin_edge.sv
`timescale 1ns/1ps
// ============================================================
// pin synchroniser and selectable edge detector
// ============================================================
module ifc_pin_edge
    import ifc_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] rise_sel,
    output logic [WIDTH-1:0] edge_hit
);

    initial begin
        if (WIDTH < 1) begin
            $error("ifc_pin_edge: WIDTH must be at least one");
        end
    end

    // ========================================================
    // one synchroniser and detector per pin
    // ========================================================
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            logic s1_q; // metastable stage, read only by s2_q
            logic s2_q;
            logic s3_q;
            logic level_q; // last agreed level
            logic primed_q; // first agreement seen
            logic agree;

            // three flops; the first only feeds the second
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= pin[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            // a change counts once stages two and three agree
            assign agree = (s2_q == s3_q);

            // first agreement after reset only loads the level,
            // so a pin held low at reset is no false edge
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    level_q <= 1'b0;
                    primed_q <= 1'b0;
                end else if (agree) begin
                    level_q <= s3_q;
                    primed_q <= 1'b1;
                end
            end

            // rising when the select bit is one, falling otherwise
            assign edge_hit[gi] = agree && primed_q &&
                (s3_q != level_q) &&
                (rise_sel[gi] ? s3_q : !s3_q);
        end
    endgenerate

endmodule

// >>> rtl/ifc_prio_pick.sv
`timescale 1ns/1ps
// ============================================================
// fixed priority picker: the lowest set index wins
// ============================================================
module ifc_prio_pick
    import ifc_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int IDX_W = 5
) (
    input wire logic [WIDTH-1:0] req,
    output logic found,
    output logic [IDX_W-1:0] index
);

    initial begin
        if ((1 << IDX_W) < WIDTH) begin
            $error("ifc_prio_pick: IDX_W too small for WIDTH");
        end
    end

    // scan from the top down so the lowest request is kept last
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = IDX_W'(i);
            end
        end
    end

endmodule

// >>> rtl/ifc_interrupt_flag_controller.sv
`timescale 1ns/1ps
// Summary of operation
// - serial one done sets second register bit4
// - second register low nibble reads zero, fixed
// - eight shared flags set by selected edge
// - shared flag register resets to zero
// - flags persist after acceptance until cleared
// - writing zero clears, writing one keeps
// - twelve external inputs: four plus eight
// - vectored lines rise or fall per select
// - vectored flag sets only in interrupt mode
// - first enable bit gates vectored line
// - vectored lines use vectors seven to four
// - line zero highest, line three lowest
// - shared lines rise or fall per select
// - third enable bit gates shared line
// - all shared lines raise vector eight
// - shared flags set even in port use
// - 21 peripheral sources, vectors 23 to 9
// - highest priority enabled request wins
// - accept only while global mask is zero
// - core finishes instruction, then stacks state
// - acceptance sets mask; vector handed over
// - clear colliding with request still interrupts
module ifc_interrupt_flag_controller
    import ifc_pkg::*;
#(
    parameter int N_VEC_LINES = NUM_VEC_LINES,
    parameter int N_SHARED = NUM_SHARED,
    parameter int N_PERIPH = NUM_PERIPH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [N_VEC_LINES-1:0] vectored_ext_lines,
    input wire logic [N_SHARED-1:0] shared_ext_lines,
    input wire logic [N_VEC_LINES-1:0] port_mode_irq_sel,
    input wire logic [N_PERIPH-1:0] periph_events,
    input wire logic ccr_mask_bit,
    input wire logic cpu_accept,
    output logic irq_req,
    output logic [VEC_W-1:0] irq_vector,
    output logic mask_set
);

    // ========================================================
    // elaboration checks
    // ========================================================
    // the register layout is fixed, so only the documented sizes fit
    initial begin
        if (N_VEC_LINES != NUM_VEC_LINES || N_SHARED != NUM_SHARED ||
            N_PERIPH != NUM_PERIPH) begin
            $error("ifc: source counts must match the register map");
        end
    end

    // ========================================================
    // declarations
    // ========================================================
    logic [3:0] line_flag_q; // vectored line request flags
    logic [3:0] line_en_q; // vectored line enables
    logic [3:0] line_edge_q; // vectored line edge selects
    logic [7:0] shared_flag_q; // shared line request flags
    logic [7:0] shared_en_q; // shared line enables
    logic [7:0] shared_edge_q; // shared line edge selects
    logic [20:0] periph_flag_q; // peripheral request flags
    logic [20:0] periph_en_q; // peripheral enables
    logic [3:0] line_hit; // selected edge seen on a vectored pin
    logic [7:0] shared_hit; // selected edge seen on a shared pin
    logic [3:0] line_clr; // software clear strobes
    logic [7:0] shared_clr;
    logic [20:0] periph_clr;
    logic [NUM_VECTORS-1:0] vec_pend; // pending, per vector number
    logic pick_found;
    logic [VEC_W-1:0] pick_vec;
    logic [31:0] rd_word; // read mux output
    logic addr_ok; // address phase taken this cycle
    logic wr_q; // data phase of a write pending
    logic [ADDR_W-1:0] wr_addr_q; // address of that write
    logic [7:0] wd; // write data byte
    logic [15:0] wd16; // write data, extra registers
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic irq_req_q;
    logic [VEC_W-1:0] irq_vector_q;
    logic mask_set_q;

    // ========================================================
    // pin edge detection
    // ========================================================
    // vectored lines; the mode gate is applied at the flag
    ifc_pin_edge #(
        .WIDTH(NUM_VEC_LINES)
    ) u_line_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(vectored_ext_lines),
        .rise_sel(line_edge_q),
        .edge_hit(line_hit)
    );

    // shared lines watch the pad level, which carries the port's
    // own output too, so port use still raises flags
    ifc_pin_edge #(
        .WIDTH(NUM_SHARED)
    ) u_shared_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(shared_ext_lines),
        .rise_sel(shared_edge_q),
        .edge_hit(shared_hit)
    );

    // ========================================================
    // bus slave: address phase capture
    // ========================================================
    // zero wait states: every transfer completes in its data phase
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ ||
        htrans == 2'b11);

    // the address is sampled every cycle; wr_q marks a write whose data follows next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_q <= addr_ok && hwrite;
            wr_addr_q <= haddr[ADDR_W-1:0];
        end
    end

    assign wd = hwdata[7:0];
    assign wd16 = hwdata[15:0];

    // the slave never stalls and never errors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= HRESP_OKAY;
        end
    end

    // ========================================================
    // write-zero clear strobes
    // ========================================================
    // a zero bit in the written byte clears, a one leaves it alone
    always_comb begin
        line_clr = '0;
        shared_clr = '0;
        periph_clr = '0;
        if (wr_q) begin
            case (wr_addr_q)
                OFS_FIRST_REQ: begin
                    line_clr = ~wd[3:0];
                    periph_clr[PIDX_TIMER_B1] = !wd[BIT_TIMER_B1];
                    periph_clr[PIDX_TIMER_A] = !wd[BIT_TIMER_A];
                end
                OFS_SECOND_REQ: begin
                    // bits 3 to 0 carry no flag, so writes do nothing
                    periph_clr[PIDX_DIRECT] = !wd[BIT_DIRECT];
                    periph_clr[PIDX_ADC] = !wd[BIT_ADC];
                    periph_clr[PIDX_SERIAL1] = !wd[BIT_SERIAL1];
                end
                OFS_SHARED_REQ: begin
                    shared_clr = ~wd;
                end
                OFS_EXTRA_REQ: begin
                    periph_clr[20:PIDX_EXTRA] = ~wd16;
                end
                default: begin
                    // other offsets clear nothing
                end
            endcase
        end
    end

    // ========================================================
    // request flags
    // ========================================================
    // a set in the same cycle as a clear wins, so a colliding
    // request is never lost; acceptance never touches a flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_flag_q <= '0;
        end else begin
            line_flag_q <= (line_flag_q & ~line_clr) |
                (line_hit & port_mode_irq_sel);
        end
    end

    // shared flags: set on any selected edge, whatever the pin mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shared_flag_q <= RST_REG8;
        end else begin
            shared_flag_q <= (shared_flag_q & ~shared_clr) |
                shared_hit;
        end
    end

    // peripheral flags, one event pulse each (serial one included)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_flag_q <= '0;
        end else begin
            periph_flag_q <= (periph_flag_q & ~periph_clr) |
                periph_events;
        end
    end

    // ========================================================
    // enable and edge select registers
    // ========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_en_q <= '0;
            shared_en_q <= RST_REG8;
            periph_en_q <= '0;
        end else if (wr_q) begin
            case (wr_addr_q)
                OFS_FIRST_EN: begin
                    line_en_q <= wd[3:0];
                    periph_en_q[PIDX_TIMER_B1] <= wd[BIT_TIMER_B1];
                    periph_en_q[PIDX_TIMER_A] <= wd[BIT_TIMER_A];
                end
                OFS_SECOND_EN: begin
                    periph_en_q[PIDX_DIRECT] <= wd[BIT_DIRECT];
                    periph_en_q[PIDX_ADC] <= wd[BIT_ADC];
                    periph_en_q[PIDX_SERIAL1] <= wd[BIT_SERIAL1];
                end
                OFS_THIRD_EN: begin
                    shared_en_q <= wd;
                end
                OFS_EXTRA_EN: begin
                    periph_en_q[20:PIDX_EXTRA] <= wd16;
                end
                default: begin
                    // not an enable register
                end
            endcase
        end
    end

    // edge selects: one picks rising, zero picks falling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_edge_q <= '0;
            shared_edge_q <= RST_REG8;
        end else if (wr_q) begin
            case (wr_addr_q)
                OFS_FIRST_EDGE: begin
                    line_edge_q <= wd[3:0];
                end
                OFS_SECOND_EDGE: begin
                    shared_edge_q <= wd;
                end
                default: begin
                    // not an edge register
                end
            endcase
        end
    end

    // ========================================================
    // pending requests per vector number
    // ========================================================
    // a disabled source keeps its flag but is not recognised
    always_comb begin
        vec_pend = '0;
        for (int i = 0; i < NUM_VEC_LINES; i++) begin
            vec_pend[VEC_FIRST_LINE + i] =
                line_flag_q[i] && line_en_q[i];
        end
        vec_pend[VEC_SHARED] =
            |(shared_flag_q & shared_en_q);
        // more sources than vectors: the tail shares the last one
        for (int k = 0; k < NUM_PERIPH; k++) begin
            if (VEC_PERIPH_FIRST + k <= VEC_PERIPH_LAST) begin
                vec_pend[VEC_PERIPH_FIRST + k] =
                    vec_pend[VEC_PERIPH_FIRST + k] ||
                    (periph_flag_q[k] && periph_en_q[k]);
            end else begin
                vec_pend[VEC_PERIPH_LAST] = vec_pend[VEC_PERIPH_LAST] ||
                    (periph_flag_q[k] && periph_en_q[k]);
            end
        end
    end

    // lower vector number wins, so line 0 beats line 3
    ifc_prio_pick #(
        .WIDTH(NUM_VECTORS),
        .IDX_W(VEC_W)
    ) u_pick (
        .req(vec_pend),
        .found(pick_found),
        .index(pick_vec)
    );

    // ========================================================
    // core handshake
    // ========================================================
    // the request is held off while the mask bit is one; the core
    // finishes its instruction and stacks before it accepts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req_q <= 1'b0;
            irq_vector_q <= '0;
        end else begin
            irq_req_q <= pick_found && !ccr_mask_bit;
            irq_vector_q <= pick_vec;
        end
    end

    // acceptance of a live request asks the core to set its mask;
    // flags are left as they are until software clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_set_q <= 1'b0;
        end else begin
            mask_set_q <= cpu_accept && irq_req_q;
        end
    end

    // ========================================================
    // read mux
    // ========================================================
    // built from the address phase so data stands in the data phase;
    // reserved bits read zero except the fixed one
    always_comb begin
        rd_word = '0;
        case (haddr[ADDR_W-1:0])
            OFS_FIRST_REQ: begin
                rd_word[7:0] = RST_FIRST_REQ;
                rd_word[3:0] = line_flag_q;
                rd_word[BIT_TIMER_B1] = periph_flag_q[PIDX_TIMER_B1];
                rd_word[BIT_TIMER_A] = periph_flag_q[PIDX_TIMER_A];
            end
            OFS_SECOND_REQ: begin
                rd_word[BIT_DIRECT] = periph_flag_q[PIDX_DIRECT];
                rd_word[BIT_ADC] = periph_flag_q[PIDX_ADC];
                rd_word[BIT_SERIAL1] = periph_flag_q[PIDX_SERIAL1];
            end
            OFS_SHARED_REQ: begin
                rd_word[7:0] = shared_flag_q;
            end
            OFS_FIRST_EN: begin
                rd_word[3:0] = line_en_q;
                rd_word[BIT_TIMER_B1] = periph_en_q[PIDX_TIMER_B1];
                rd_word[BIT_TIMER_A] = periph_en_q[PIDX_TIMER_A];
            end
            OFS_SECOND_EN: begin
                rd_word[BIT_DIRECT] = periph_en_q[PIDX_DIRECT];
                rd_word[BIT_ADC] = periph_en_q[PIDX_ADC];
                rd_word[BIT_SERIAL1] = periph_en_q[PIDX_SERIAL1];
            end
            OFS_THIRD_EN: begin
                rd_word[7:0] = shared_en_q;
            end
            OFS_FIRST_EDGE: begin
                rd_word[3:0] = line_edge_q;
            end
            OFS_SECOND_EDGE: begin
                rd_word[7:0] = shared_edge_q;
            end
            OFS_EXTRA_REQ: begin
                rd_word[15:0] = periph_flag_q[20:PIDX_EXTRA];
            end
            OFS_EXTRA_EN: begin
                rd_word[15:0] = periph_en_q[20:PIDX_EXTRA];
            end
            OFS_STATUS: begin
                rd_word[VEC_W-1:0] = irq_vector_q;
                rd_word[BIT_STAT_REQ] = irq_req_q;
            end
            default: begin
                // unmapped offsets read as zero
            end
        endcase
    end

    // read data registered for the data phase; held otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= rd_word;
        end
    end

    // ========================================================
    // outputs, all straight from flops
    // ========================================================
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign irq_req = irq_req_q;
    assign irq_vector = irq_vector_q;
    assign mask_set = mask_set_q;

endmodule

// >>> bench/ifc_irq_monitor.sv
`timescale 1ns/1ps
// ========================================
// checks on the controller's top ports
module ifc_irq_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ccr_mask_bit,
    input wire logic cpu_accept,
    input wire logic irq_req,
    input wire logic [4:0] irq_vector,
    input wire logic mask_set
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_mask; ccr_mask_bit |=> !irq_req; endproperty
    a_mask: assert property (p_mask) else $error("masked req");
    property p_vec; irq_req |-> irq_vector inside {[5'd4:5'd23]}; endproperty
    a_vec: assert property (p_vec) else $error("vector range");
    property p_acc; cpu_accept && irq_req |=> mask_set; endproperty
    a_acc: assert property (p_acc) else $error("no mask");
    property p_noacc; !(cpu_accept && irq_req) |=> !mask_set; endproperty
    a_noacc: assert property (p_noacc) else $error("stray");
    // the flag is not consumed by acceptance, so the request must stay
    property p_keep; cpu_accept && irq_req ##1 !ccr_mask_bit |=> irq_req;
    endproperty
    a_keep: assert property (p_keep) else $error("req lost");
    property p_rst; $rose(hresetn) |-> !irq_req && !mask_set; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind ifc_interrupt_flag_controller ifc_irq_monitor ifc_irq_monitor_i (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .ccr_mask_bit(ccr_mask_bit), .cpu_accept(cpu_accept),
    .irq_req(irq_req), .irq_vector(irq_vector), .mask_set(mask_set));

// >>> bench/ifc_core_model.sv
`timescale 1ns/1ps
// ========================================
// core: takes one request, masks on the pulse, unmasks on return
module ifc_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_req,
    input wire logic mask_set,
    input wire logic unmask,
    output logic ccr_mask_bit,
    output logic cpu_accept
);
    // guard on mask_set stops a second take before the mask lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_accept <= 1'b0;
        end else begin
            cpu_accept <= irq_req && !ccr_mask_bit && !cpu_accept
                && !mask_set;
        end
    end
    // mask rises on the pulse and falls only on return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ccr_mask_bit <= 1'b0;
        end else if (mask_set) begin
            ccr_mask_bit <= 1'b1;
        end else if (unmask) begin
            ccr_mask_bit <= 1'b0;
        end
    end
endmodule

// >>> bench/tb_interrupt_flag_controller.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED %0t got %h", $time, a); end end
module tb_interrupt_flag_controller;
    import ifc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_req, mask_set;
    logic ccr_mask_bit, cpu_accept, unmask;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [3:0] vl, pm;
    logic [7:0] sl;
    logic [20:0] pe;
    logic [4:0] irq_vector;
    int failures = 0, checked = 0, cycles = 0;
    ifc_interrupt_flag_controller ifc_interrupt_flag_controller_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .vectored_ext_lines(vl), .shared_ext_lines(sl),
        .port_mode_irq_sel(pm), .periph_events(pe),
        .ccr_mask_bit(ccr_mask_bit), .cpu_accept(cpu_accept),
        .irq_req(irq_req), .irq_vector(irq_vector), .mask_set(mask_set));
    ifc_core_model ifc_core_model_i (.hclk(hclk), .hresetn(hresetn),
        .irq_req(irq_req), .mask_set(mask_set), .unmask(unmask),
        .ccr_mask_bit(ccr_mask_bit), .cpu_accept(cpu_accept));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop;
        end
    end
    // one single word transfer; idle edge after so reads see writes
    task automatic xf(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        @(posedge hclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask
    // let the core return, then wait for the mask pulse
    task automatic take(input logic [4:0] v);
        int i;
        unmask <= 1'b1;
        @(posedge hclk);
        unmask <= 1'b0;
        for (i = 0; i < 30 && mask_set !== 1'b1; i++) @(posedge hclk);
        `CHK(mask_set, 1'b1)
        `CHK(irq_vector, v)
    endtask
    task automatic report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_serial;
        rd(OFS_SHARED_REQ, 32'h0000_0000);
        xf(1'b1, OFS_SECOND_EN, 32'h0000_0010);
        pe[PIDX_SERIAL1] <= 1'b1;
        @(posedge hclk);
        pe <= '0;
        take(5'd13);
        rd(OFS_SECOND_REQ, 32'h0000_0010);
        xf(1'b1, OFS_SECOND_REQ, 32'hFFFF_FFFF);
        rd(OFS_SECOND_REQ, 32'h0000_0010);
        xf(1'b1, OFS_SECOND_REQ, 32'h0000_0000);
        rd(OFS_SECOND_REQ, 32'h0000_0000);
        $display("serial test done");
    endtask
    task automatic t_shared;
        xf(1'b1, OFS_SECOND_EDGE, 32'h0000_0001);
        xf(1'b1, OFS_THIRD_EN, 32'h0000_0001);
        sl <= 8'h81;
        repeat (8) @(posedge hclk);
        `CHK(irq_req, 1'b0)
        rd(OFS_SHARED_REQ, 32'h0000_0001);
        take(5'd8);
        xf(1'b1, OFS_SHARED_REQ, 32'h0000_0000);
        $display("shared test done");
    endtask
    task automatic t_vectored;
        pm <= 4'hF;
        xf(1'b1, OFS_FIRST_EN, 32'h0000_000F);
        vl <= 4'b0110;
        take(5'd4);
        rd(OFS_FIRST_REQ, 32'h0000_0019);
        $display("vectored test done");
    endtask
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, pm, pe, sl, unmask} = '0;
        hsel = 1'b1;
        vl = 4'hF;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_serial;
        t_shared;
        t_vectored;
        report_and_stop;
    end
endmodule
